// >>> adsc_conv_model.sv
// converter stand-in: answers each start after a short or long delay
// assumes start and channel arrive as registered levels on sys_clk
`timescale 1ns/1ps
module adsc_conv_model
   import adsc_pkg::*;
(
   // clock and pacing
   input wire logic sys_clk,
   input wire logic slow,
   // converter pins
   input wire logic adc_start,
   input wire logic [CH_W-1:0] mux_channel,
   output logic adc_done,
   output logic [RES_W-1:0] adc_result
);
   logic [CH_W-1:0] ch;
   initial begin
      adc_done = 1'b0;
      adc_result = 12'h0aa5;
   end
   // result tracks the channel so the bench can tell entries apart
   always @(posedge sys_clk) begin
      if (adc_start === 1'b1) begin
         ch = mux_channel;
         repeat (slow ? 20 : 2) @(posedge sys_clk);
         #1 adc_result = {ch, 7'h35};
         @(posedge sys_clk);
         #1 adc_done = 1'b1;
         repeat (4) @(posedge sys_clk);
         #1 adc_done = 1'b0;
         adc_result = ~adc_result; // hold time over, stale value unusable
      end
   end
endmodule

// >>> adsc_ctrl.sv
// acquisition control: trigger select, pacer, channel scan, gain, fifo, irq
// assumes host i/o strobes on sys_clk; converter done/result arrive from pins
`timescale 1ns/1ps

// Notes on behaviour
// [R1] interrupt request is a level held until any write to the clear register
// [R2] host writes the clear register after each serviced interrupt
// [R3] each fifo entry holds a result and its channel number
// [R4] one 32-bit data-port read returns one whole fifo entry
// [R5] result in bits 11..0, channel in bits 20..16, other bits zero
// [R6] a conversion starts on each rising edge of the selected trigger; code ignores edges that arrive while a conversion is busy
// [R7] two trigger sources only, software or pacer, chosen by the select bit
// [R8] select bit 0: any write to the software trigger register starts one; code ignores such writes while a conversion is busy
// [R9] select bit 1: two cascaded counter stages trigger at a fixed rate
// [R10] trigger source, transfer and interrupt source are set independently
// [R11] auto-scan off: convert the channel held in the channel register
// [R12] auto-scan on: scan from channel 0 up to the channel register value
// [R13] during auto-scan each trigger edge advances the channel by one; code does not advance it on edges ignored while busy
// [R14] after the ending channel wrap to 0, until auto-scan is cleared
// [R15] four gain levels, 1, 10, 100 and 1000
// [R16] one gain setting applies to every channel, scanning or not
// [R17] fifo holds 1024 entries
// [R18] when full, new results are dropped, stored entries kept
// [R19] host drains the fifo before it fills
// [R20] gain code 00 is x1, 01 is x10, 10 is x100
// [R21] empty, half-full and full status flags read 0 when true
// [R22] irq source bit 0 selects end of conversion, 1 selects half-full
// [R23] trigger mode: auto-scan bit 0, source bit 1, gain read back in 3..2
// [R24] gain code 11 is x1000
// [R25] setting auto-scan loads the scan channel with 0
module adsc_ctrl
   import adsc_pkg::*;
#(
   parameter logic [15:0] PACER_DIV1 = PACER_DIV1_DEF,
   parameter logic [15:0] PACER_DIV2 = PACER_DIV2_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // host i/o port
   input wire logic io_space,
   input wire logic [3:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_wdata,
   output logic [31:0] io_rdata,
   output logic io_rd_ack,
   // converter and front end
   output logic adc_start,
   input wire logic adc_done,
   input wire logic [RES_W-1:0] adc_result,
   output logic [CH_W-1:0] mux_channel,
   output logic [GAIN_W-1:0] pga_gain_code,
   // interrupt request level
   output logic irq_level
);

   adsc_state_t s_r;
   adsc_state_t s_nxt;
   adsc_entry_t fifo_mem [FIFO_DEPTH];
   adsc_entry_t push_entry;
   logic push;

   // next-state logic for the whole block
   always_comb begin
      logic wr_regs;
      logic rd_regs;
      logic rd_data;
      logic pop;
      logic trig;
      logic pace;
      logic done_edge;
      logic empty;
      logic full;
      logic half_before;
      logic half_after;
      logic eoc_evt;
      logic half_evt;
      logic clr;
      adsc_entry_t head;
      logic [31:0] word;
      wr_regs = io_wr && (io_space == SPACE_REGS);
      rd_regs = io_rd && (io_space == SPACE_REGS);
      rd_data = io_rd && (io_space == SPACE_DATA);
      pop = 1'b0;
      trig = 1'b0;
      pace = 1'b0;
      done_edge = 1'b0;
      empty = (s_r.count == '0);
      full = (s_r.count == FIFO_FULL_CNT);
      half_before = (s_r.count >= FIFO_HALF_CNT);
      half_after = 1'b0;
      eoc_evt = 1'b0;
      half_evt = 1'b0;
      clr = 1'b0;
      head = fifo_mem[s_r.rd_ptr];
      word = WORD_ZERO;
      push = 1'b0;
      push_entry = '{ch: s_r.conv_ch, res: s_r.res_s2};
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      s_nxt.rd_ack = 1'b0;

      // converter handshake pins, two flops before use
      s_nxt.done_s1 = adc_done;
      s_nxt.done_s2 = s_r.done_s1;
      s_nxt.res_s1 = adc_result;
      s_nxt.res_s2 = s_r.res_s1;
      s_nxt.done_prev = s_r.done_s2;
      done_edge = s_r.done_s2 && !s_r.done_prev;

      // register writes; each field written only by its own register
      if (wr_regs) begin
         if (io_addr == OFF_CHAN_DATA) begin
            s_nxt.chan_reg = io_wdata[CH_W-1:0]; // [R11] [R12]
         end else if (io_addr == OFF_GAIN_STAT) begin
            s_nxt.gain = io_wdata[GAIN_W-1:0]; // [R15] [R20] [R24]
         end else if (io_addr == OFF_TRIG_MODE) begin
            s_nxt.auto_scan_enable = io_wdata[TM_AUTO_SCAN_ENABLE_BIT]; // [R23]
            s_nxt.trigger_source_select = io_wdata[TM_TRIGGER_SOURCE_SELECT_BIT]; // [R23] [R10]
            if (io_wdata[TM_AUTO_SCAN_ENABLE_BIT] && !s_r.auto_scan_enable) begin
               s_nxt.scan_ch = CH_ZERO; // [R25]
            end
         end else if (io_addr == OFF_IRQ_CTRL) begin
            s_nxt.irq0_source_select = io_wdata[IC_IRQ0_SOURCE_SELECT_BIT]; // [R10] [R22]
            s_nxt.isc1 = io_wdata[IC_ISC1_BIT];
            s_nxt.ffen = io_wdata[IC_FFEN_BIT];
         end else if (io_addr == OFF_SW_TRIG) begin
            trig = !s_r.trigger_source_select; // [R8]
         end else if (io_addr == OFF_IRQ_CLEAR) begin
            clr = 1'b1; // [R1]
         end
      end

      // two cascaded pacer stages, held in reload while software-triggered
      if (s_r.trigger_source_select) begin
         if (s_r.div1 == '0) begin
            s_nxt.div1 = PACER_DIV1 - 16'h0001;
            if (s_r.div2 == '0) begin
               s_nxt.div2 = PACER_DIV2 - 16'h0001;
               pace = 1'b1; // [R9]
            end else begin
               s_nxt.div2 = s_r.div2 - 16'h0001;
            end
         end else begin
            s_nxt.div1 = s_r.div1 - 16'h0001;
         end
      end else begin
         s_nxt.div1 = PACER_DIV1 - 16'h0001;
         s_nxt.div2 = PACER_DIV2 - 16'h0001;
      end
      trig = trig || (s_r.trigger_source_select && pace); // [R7]

      // trigger edge: start conversion, advance scan; ignored while busy
      if (trig && !s_r.busy) begin
         s_nxt.start = 1'b1; // [R6]
         s_nxt.busy = 1'b1;
         if (s_r.auto_scan_enable) begin
            s_nxt.conv_ch = s_r.scan_ch; // [R12]
            if (s_r.scan_ch >= s_r.chan_reg) begin
               s_nxt.scan_ch = CH_ZERO; // [R14]
            end else begin
               s_nxt.scan_ch = s_r.scan_ch + PTR_ONE[CH_W-1:0]; // [R13]
            end
         end else begin
            s_nxt.conv_ch = s_r.chan_reg; // [R11]
         end
      end

      // multiplexer holds the converting channel while busy, else the channel that the next trigger converts
      if (s_nxt.busy) begin
         s_nxt.mux_ch = s_nxt.conv_ch;
      end else if (s_nxt.auto_scan_enable) begin
         s_nxt.mux_ch = s_nxt.scan_ch; // [R12]
      end else begin
         s_nxt.mux_ch = s_nxt.chan_reg; // [R11]
      end

      // end of conversion: store result and channel unless full or disabled
      if (done_edge && s_r.busy) begin
         s_nxt.busy = 1'b0;
         eoc_evt = 1'b1;
         push = !full && !s_r.ffen; // [R3] [R18]
      end

      // read decode; data reads pop the fifo head
      if (rd_regs) begin
         s_nxt.rd_ack = 1'b1;
         if (io_addr == OFF_CHAN_DATA) begin
            word[DW_RES_LSB +: RES_W] = head.res;
            pop = !empty;
         end else if (io_addr == OFF_GAIN_STAT) begin
            word[ST_EMPTY_BIT] = !empty; // [R21]
            word[ST_HALF_BIT] = !half_before; // [R21]
            word[ST_FULL_BIT] = !full; // [R21]
            word[ST_BUSY_BIT] = !s_r.busy;
         end else if (io_addr == OFF_TRIG_MODE) begin
            word[TM_AUTO_SCAN_ENABLE_BIT] = s_r.auto_scan_enable; // [R23]
            word[TM_TRIGGER_SOURCE_SELECT_BIT] = s_r.trigger_source_select; // [R23]
            word[TM_GAIN_LSB +: GAIN_W] = s_r.gain; // [R23]
         end else if (io_addr == OFF_IRQ_CTRL) begin
            word[IC_IRQ0_SOURCE_SELECT_BIT] = s_r.irq0_source_select;
            word[IC_ISC1_BIT] = s_r.isc1;
            word[IC_FFEN_BIT] = s_r.ffen;
         end
         s_nxt.rdata = word;
      end else if (rd_data) begin
         s_nxt.rd_ack = 1'b1;
         if (io_addr == OFF_SAMPLE_CH) begin
            word[DW_RES_LSB +: RES_W] = head.res; // [R5]
            word[DW_CH_LSB +: CH_W] = head.ch; // [R5]
            pop = !empty; // [R4]
         end
         s_nxt.rdata = word;
      end

      // pointer and fill count update
      if (s_r.ffen) begin
         s_nxt.wr_ptr = '0;
         s_nxt.rd_ptr = '0;
         s_nxt.count = '0;
      end else begin
         if (push) begin
            s_nxt.wr_ptr = s_r.wr_ptr + PTR_ONE; // [R17]
         end
         if (pop) begin
            s_nxt.rd_ptr = s_r.rd_ptr + PTR_ONE;
         end
         if (push && !pop) begin
            s_nxt.count = s_r.count + FIFO_ONE;
         end else if (pop && !push) begin
            s_nxt.count = s_r.count - FIFO_ONE;
         end
      end
      half_after = (s_nxt.count >= FIFO_HALF_CNT);
      half_evt = half_after && !half_before;

      // level request: a new event outranks a clear in the same cycle
      if ((!s_r.irq0_source_select && eoc_evt) || (s_r.irq0_source_select && half_evt)) begin
         s_nxt.irq = 1'b1; // [R1] [R22]
      end else if (clr) begin
         s_nxt.irq = 1'b0; // [R1]
      end
   end

   // fifo storage; write only, read is the head lookup above
   always_ff @(posedge sys_clk) begin
      if (push) begin
         fifo_mem[s_r.wr_ptr] <= push_entry; // [R3]
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from state flops
   assign io_rdata = s_r.rdata;
   assign io_rd_ack = s_r.rd_ack;
   assign adc_start = s_r.start;
   assign mux_channel = s_r.mux_ch;
   assign pga_gain_code = s_r.gain; // [R16]
   assign irq_level = s_r.irq;

endmodule

// >>> adsc_monitor.sv
// port checker for the acquisition control block
// assumes one clock domain, bound onto adsc_ctrl
`timescale 1ns/1ps
module adsc_monitor
   import adsc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // host port
   input wire logic io_space,
   input wire logic [3:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_wdata,
   input wire logic [31:0] io_rdata,
   input wire logic io_rd_ack,
   // converter side and irq
   input wire logic adc_start,
   input wire logic [CH_W-1:0] mux_channel,
   input wire logic [GAIN_W-1:0] pga_gain_code,
   input wire logic irq_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // decoded register writes
   wire logic clr_wr = io_wr && !io_space && io_addr == OFF_IRQ_CLEAR;
   wire logic gain_wr = io_wr && !io_space && io_addr == OFF_GAIN_STAT;
   wire logic [GAIN_W-1:0] wgain = io_wdata[GAIN_W-1:0];
   irq_hold_a: assert property (irq_level && !clr_wr |=> irq_level)
      else $error("irq dropped without a clear write");
   rd_ack_a: assert property (io_rd |=> io_rd_ack)
      else $error("read not answered next cycle");
   ack_only_a: assert property (!io_rd |=> !io_rd_ack)
      else $error("answer without a read");
   word_zeros_a: assert property (io_rd_ack && $past(io_space) |->
      io_rdata[31:21] == 11'h000 && io_rdata[15:12] == 4'h0)
      else $error("combined word has bits outside its fields");
   start_pulse_a: assert property (adc_start |=> !adc_start [*4])
      else $error("start repeated while converting");
   mux_hold_a: assert property (adc_start |=> $stable(mux_channel) [*2])
      else $error("channel moved during conversion");
   gain_set_a: assert property (gain_wr |=> pga_gain_code == $past(wgain))
      else $error("gain code not taken from write");
   gain_keep_a: assert property (!gain_wr |=> $stable(pga_gain_code))
      else $error("gain changed without a write");
   // main scenarios reached
   cover property (irq_level && clr_wr);
   cover property (io_rd_ack && io_rdata[20:16] == 5'h02);
   cover property (gain_wr ##1 pga_gain_code == GAIN_X1000);
endmodule
bind adsc_ctrl adsc_monitor u_mon (.sys_clk(sys_clk), .arst_n(arst_n), .io_space(io_space),
   .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
   .io_rd_ack(io_rd_ack), .adc_start(adc_start), .mux_channel(mux_channel),
   .pga_gain_code(pga_gain_code), .irq_level(irq_level));

// >>> adsc_pkg.sv
// package for the scan/trigger/fifo acquisition control block
// assumes one 250 MHz clock and a 16-bit i/o port plus a 32-bit data port
package adsc_pkg;

   // clock rate and widths
   localparam int CLK_MHZ = 250;
   localparam int CH_W = 5;
   localparam int RES_W = 12;
   localparam int GAIN_W = 2;
   localparam int FIFO_AW = 10;
   localparam int FIFO_DEPTH = 1024;
   localparam logic [FIFO_AW:0] FIFO_FULL_CNT = 11'h400;
   localparam logic [FIFO_AW:0] FIFO_HALF_CNT = 11'h200;
   localparam logic [FIFO_AW:0] FIFO_ONE = 11'h001;
   localparam logic [FIFO_AW-1:0] PTR_ONE = 10'h001;

   // register offsets in the 16-bit port space
   localparam logic [3:0] OFF_CHAN_DATA = 4'h0;
   localparam logic [3:0] OFF_GAIN_STAT = 4'h2;
   localparam logic [3:0] OFF_TRIG_MODE = 4'h4;
   localparam logic [3:0] OFF_IRQ_CTRL = 4'h6;
   localparam logic [3:0] OFF_SW_TRIG = 4'h8;
   localparam logic [3:0] OFF_IRQ_CLEAR = 4'ha;
   // offset in the 32-bit port space
   localparam logic [3:0] OFF_SAMPLE_CH = 4'h0;

   // port space select
   localparam logic SPACE_REGS = 1'b0;
   localparam logic SPACE_DATA = 1'b1;

   // trigger mode fields
   localparam int TM_AUTO_SCAN_ENABLE_BIT = 0;
   localparam int TM_TRIGGER_SOURCE_SELECT_BIT = 1;
   localparam int TM_GAIN_LSB = 2;
   // interrupt control fields
   localparam int IC_IRQ0_SOURCE_SELECT_BIT = 0;
   localparam int IC_ISC1_BIT = 1;
   localparam int IC_FFEN_BIT = 2;
   // status fields, all active low
   localparam int ST_EMPTY_BIT = 0;
   localparam int ST_HALF_BIT = 1;
   localparam int ST_FULL_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   // combined data word fields
   localparam int DW_RES_LSB = 0;
   localparam int DW_CH_LSB = 16;

   // gain codes
   localparam logic [GAIN_W-1:0] GAIN_X1 = 2'h0;
   localparam logic [GAIN_W-1:0] GAIN_X10 = 2'h1;
   localparam logic [GAIN_W-1:0] GAIN_X100 = 2'h2;
   localparam logic [GAIN_W-1:0] GAIN_X1000 = 2'h3;

   // pacer stage divisors (plain defaults)
   localparam logic [15:0] PACER_DIV1_DEF = 16'h000a;
   localparam logic [15:0] PACER_DIV2_DEF = 16'h0019;

   // reset values
   localparam logic [CH_W-1:0] CH_ZERO = 5'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // one fifo entry
   typedef struct packed {
      logic [CH_W-1:0] ch;
      logic [RES_W-1:0] res;
   } adsc_entry_t;

   // state of the control block apart from the fifo storage
   typedef struct packed {
      logic [CH_W-1:0] chan_reg;
      logic [GAIN_W-1:0] gain;
      logic auto_scan_enable;
      logic trigger_source_select;
      logic irq0_source_select;
      logic isc1;
      logic ffen;
      logic [CH_W-1:0] scan_ch;
      logic [CH_W-1:0] conv_ch;
      logic [CH_W-1:0] mux_ch;
      logic busy;
      logic start;
      logic [FIFO_AW-1:0] wr_ptr;
      logic [FIFO_AW-1:0] rd_ptr;
      logic [FIFO_AW:0] count;
      logic irq;
      logic [31:0] rdata;
      logic rd_ack;
      logic [15:0] div1;
      logic [15:0] div2;
      logic done_s1;
      logic done_s2;
      logic done_prev;
      logic [RES_W-1:0] res_s1;
      logic [RES_W-1:0] res_s2;
   } adsc_state_t;

endpackage

// >>> tb.sv
// self-checking bench for the acquisition control block
// assumes the converter model and the port checker bound onto the design
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
   import adsc_pkg::*;
   logic sys_clk = 1'b0, arst_n = 1'b0, io_space = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic slow = 1'b0;
   logic [3:0] io_addr = 4'h0;
   logic [15:0] io_wdata = 16'h0000;
   logic [31:0] io_rdata, rv;
   logic io_rd_ack, adc_start, adc_done, irq_level;
   logic [RES_W-1:0] adc_result;
   logic [CH_W-1:0] mux_channel;
   logic [GAIN_W-1:0] pga_gain_code;
   int num_errors = 0, compares = 0, n;
   always #2 sys_clk = ~sys_clk;
   // small pacer divisors keep the fill short
   adsc_ctrl #(.PACER_DIV1(16'h0002), .PACER_DIV2(16'h0002)) uut (.sys_clk(sys_clk),
      .arst_n(arst_n), .io_space(io_space), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack), .adc_start(adc_start),
      .adc_done(adc_done), .adc_result(adc_result), .mux_channel(mux_channel),
      .pga_gain_code(pga_gain_code), .irq_level(irq_level));
   adsc_conv_model model (.sys_clk(sys_clk), .slow(slow), .adc_start(adc_start),
      .mux_channel(mux_channel), .adc_done(adc_done), .adc_result(adc_result));
   // register write, strobe up for one edge
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      #1 io_space = SPACE_REGS;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge sys_clk);
      #1 io_wr = 1'b0;
   endtask
   // read; the answer is registered at the taking edge
   task rd(input logic s, input logic [3:0] a);
      @(posedge sys_clk);
      #1 io_space = s;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge sys_clk);
      #1 io_rd = 1'b0;
      rv = io_rdata;
      `CHK("ack", 1'b1, io_rd_ack)
   endtask
   // bounded wait for the interrupt level
   task wait_irq;
      n = 0;
      while (irq_level !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1 n++;
      end
      `CHK("irq", 1'b1, irq_level)
   endtask
   task print_verdict;
      $display("mismatches %0d comparisons %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 arst_n = 1'b1;
      for (int g = 3; g >= 0; g--) begin
         wr(OFF_GAIN_STAT, 16'(g));
         `CHK("gain", 2'(g), pga_gain_code)
         rd(SPACE_REGS, OFF_TRIG_MODE);
         `CHK("mode", 32'(g) << 2, rv)
      end
      // fixed channel, software trigger, end-of-conversion irq
      wr(OFF_CHAN_DATA, 16'h0007);
      wr(OFF_SW_TRIG, 16'h0000);
      wait_irq();
      repeat (5) @(posedge sys_clk);
      `CHK("irq held", 1'b1, irq_level)
      rd(SPACE_REGS, OFF_GAIN_STAT);
      `CHK("status", 32'h0000_000f, rv)
      rd(SPACE_DATA, OFF_SAMPLE_CH);
      `CHK("word", {11'h000, 5'h07, 4'h0, 5'h07, 7'h35}, rv)
      wr(OFF_IRQ_CLEAR, 16'h0055);
      `CHK("irq clr", 1'b0, irq_level)
      rd(SPACE_REGS, OFF_GAIN_STAT);
      `CHK("empty", 32'h0000_000e, rv)
      // auto-scan to channel 2, slow converter, gain must not move
      slow = 1'b1;
      wr(OFF_GAIN_STAT, 16'h0001);
      wr(OFF_CHAN_DATA, 16'h0002);
      wr(OFF_TRIG_MODE, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_SW_TRIG, 16'h0000);
         wait_irq();
         wr(OFF_IRQ_CLEAR, 16'h0000);
         `CHK("gain kept", GAIN_X10, pga_gain_code)
      end
      for (int i = 0; i < 4; i++) begin
         rd(SPACE_DATA, OFF_SAMPLE_CH);
         `CHK("scan ch", 5'(i % 3), rv[20:16])
      end
      // pacer scan fills the fifo, half-full irq, then drain in order
      slow = 1'b0;
      wr(OFF_IRQ_CTRL, 16'h0001);
      wr(OFF_TRIG_MODE, 16'h0000);
      wr(OFF_TRIG_MODE, 16'h0003);
      n = 0;
      do begin
         repeat (50) @(posedge sys_clk);
         rd(SPACE_REGS, OFF_GAIN_STAT);
         n++;
      end while (rv[ST_FULL_BIT] !== 1'b0 && n < 400);
      `CHK("full", 3'b001, rv[2:0])
      `CHK("half irq", 1'b1, irq_level)
      wr(OFF_TRIG_MODE, 16'h0000);
      repeat (40) @(posedge sys_clk);
      // host drains every stored entry in order
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         rd(SPACE_DATA, OFF_SAMPLE_CH);
         `CHK("fifo ch", 5'(i % 3), rv[20:16])
      end
      rd(SPACE_REGS, OFF_GAIN_STAT);
      `CHK("drained", 4'he, rv[3:0])
      // interrupt control reads back apart from trigger settings
      wr(OFF_IRQ_CTRL, 16'h0006);
      rd(SPACE_REGS, OFF_IRQ_CTRL);
      `CHK("irq ctrl", 32'h0000_0006, rv)
      rd(SPACE_REGS, OFF_TRIG_MODE);
      `CHK("mode kept", 32'h0000_0004, rv)
      print_verdict();
   end
   // hang guard, far beyond the expected run length
   initial begin
      repeat (80000) @(posedge sys_clk);
      num_errors++;
      print_verdict();
   end
endmodule
